// File: csbg_pkg.sv
// constants, types and carriers for the clock source and burst gate
//
// Functional notes
// - take drum-derived pulses (timing rate times four) and a direct oscillator
// - every clock pulse is a short fixed-width pulse, not a square wave
// - drum clock usable always; oscillator active only in test mode
// - normal mode always selects the drum-derived clock
// - test mode follows operator choice of drum or oscillator
// - choice released, A=0 and B=1: next oscillator pulse clears B
// - choice released, A=0 and B=0: next oscillator pulse sets A
// - A=1 and B=0: next drum pulse sets B
// - A=1 and B=1: forward drum pulses, block oscillator pulses
// - oscillator held: A forced 0, first pulse clears B, later ones forwarded
// - releasing oscillator returns to drum through the flop sequence alone
// - source change in test mode keeps pulses flowing, one-period gap allowed (a switch to the oscillator can drop up to two pulses)
// - start clears rate A; next pulse clears rate B; emit while B is 0
// - normal mode with drum or tape start: continuous from start to stop
// - special sequence or operand transfer sets B, dropping exactly one pulse
// - stop sets both rate flops, ending output until next start
// - resume indications never touch the rate flops in normal mode
// - manual step: one pulse per step, that pulse sets both rate flops
// - timed step: manual step ignored; start enables slow step source 5..35
// - timed step: each slow pulse clears A, one pulse emitted, flops back to 1
package csbg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned SYS_CLK_HZ = 10_000_000;
    localparam int unsigned SYS_PERIOD_NS = 100;
    localparam int unsigned CLOCK_PERIOD_NS = 2000;
    localparam int unsigned PULSE_WIDTH_NS = 250;
    // oscillator period, longest time: round down
    localparam int unsigned OSC_PERIOD_CYC = CLOCK_PERIOD_NS / SYS_PERIOD_NS;
    // pulse width, least time: round up
    localparam int unsigned PULSE_WIDTH_CYC =
        (PULSE_WIDTH_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int unsigned DRUM_MULTIPLY = 4;
    localparam int unsigned STEP_RATE_MIN_CPS = 5;
    localparam int unsigned STEP_RATE_MAX_CPS = 35;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic SRC_SEL_RESET = 1'h1;
    localparam logic RATE_RESET = 1'h1;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        CSBG_RUN_CONT = 2'h0,
        CSBG_RUN_MAN_STEP = 2'h1,
        CSBG_RUN_AUTO_STEP = 2'h2
    } csbg_run_e;

    // panel selections, all asynchronous to clk_sys
    typedef struct packed {
        logic test_mode;
        logic osc_select;
        logic drum_start;
        logic tape_start;
        logic start;
        logic stop;
        logic step;
        logic drum_timing;
    } csbg_panel_s;

    localparam int unsigned PANEL_W = $bits(csbg_panel_s);

    // machine requests from the sequencing logic, same clock
    typedef struct packed {
        logic special_sequence_init;
        logic operand_to_prog_ctrl_transfer;
    } csbg_seq_s;

endpackage

// File: csbg_top.sv
// clock source selector and rate controller, one clock domain
`timescale 1ns/10ps
module csbg_top #(
    parameter int unsigned CLK_HZ = csbg_pkg::SYS_CLK_HZ,
    parameter int unsigned DRUM_CNT_W = 12,
    parameter int unsigned STEP_ACC_W = 24
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire csbg_pkg::csbg_panel_s panel,
    input wire csbg_pkg::csbg_run_e run_mode,
    input wire logic [5:0] step_rate_cps,
    input wire csbg_pkg::csbg_seq_s seq_req,
    output logic computer_clock,
    output logic controlled_clock,
    output logic source_sel_flop_a,
    output logic source_sel_flop_b,
    output logic rate_flop_a,
    output logic rate_flop_b,
    output logic osc_source_active
);

    ////////////////////////////////////////////////////////////////////////
    // parameter checks
    if (CLK_HZ >= (64'h1 << STEP_ACC_W)) begin : g_bad_acc
        $error("step accumulator too narrow for clock rate");
    end
    if (DRUM_CNT_W < 4) begin : g_bad_drum
        $error("drum interval counter too narrow");
    end
    // a slow drum must still fit: twice the nominal interval, unsaturated
    localparam int unsigned DRUM_SPAN =
        2 * csbg_pkg::DRUM_MULTIPLY * csbg_pkg::OSC_PERIOD_CYC;
    if ((64'h1 << DRUM_CNT_W) <= 64'(DRUM_SPAN)) begin : g_bad_span
        $error("drum interval counter cannot span a slow drum period");
    end
    if (csbg_pkg::PULSE_WIDTH_CYC >= csbg_pkg::OSC_PERIOD_CYC) begin : g_bad_w
        $error("clock pulse not shorter than the clock period");
    end
    // below twice the top rate the slow source would strobe back to back
    if (CLK_HZ < 2 * csbg_pkg::STEP_RATE_MAX_CPS) begin : g_bad_hz
        $error("step modulus too small for the step rate range");
    end
    if (csbg_pkg::STEP_RATE_MAX_CPS > 63) begin : g_bad_knob
        $error("step rate range does not fit the rate port");
    end

    ////////////////////////////////////////////////////////////////////////
    // panel synchronisers: two flops per bit before any logic reads it
    // reset to the idle pin level so no false edge follows reset
    logic [csbg_pkg::PANEL_W-1:0] panel_meta;
    logic [csbg_pkg::PANEL_W-1:0] panel_sync;
    genvar gi;
    generate
        for (gi = 0; gi < csbg_pkg::PANEL_W; gi++) begin : g_sync
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    panel_meta[gi] <= 1'h0;
                    panel_sync[gi] <= 1'h0;
                end else begin
                    panel_meta[gi] <= panel[gi];
                    panel_sync[gi] <= panel_meta[gi];
                end
            end
        end
    endgenerate

    csbg_pkg::csbg_panel_s pnl;
    csbg_pkg::csbg_panel_s pnl_d;
    assign pnl = csbg_pkg::csbg_panel_s'(panel_sync);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pnl_d <= '0;
        end else begin
            pnl_d <= pnl;
        end
    end

    // one-cycle request pulses from rising edges
    logic start_pulse;
    logic stop_pulse;
    logic step_pulse;
    logic drum_edge;
    assign start_pulse = pnl.start & ~pnl_d.start;
    assign stop_pulse = pnl.stop & ~pnl_d.stop;
    assign step_pulse = pnl.step & ~pnl_d.step;
    assign drum_edge = pnl.drum_timing & ~pnl_d.drum_timing;

    ////////////////////////////////////////////////////////////////////////
    // drum pulse multiplier: measure the timing interval, emit four strobes
    // the first interval after reset is unknown and the period is registered, so
    // strobes start at the third drum edge; a drum that stops simply stops the strobes
    logic [DRUM_CNT_W-1:0] drum_interval;
    logic [DRUM_CNT_W-1:0] drum_period;
    logic [DRUM_CNT_W-1:0] drum_phase;
    logic [2:0] drum_left;
    logic drum_stb;
    logic drum_primed;
    logic [DRUM_CNT_W-1:0] drum_quarter;
    assign drum_quarter = drum_period >> 2;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            drum_interval <= '0;
            drum_period <= '0;
            drum_primed <= 1'h0;
        end else if (drum_edge) begin
            drum_interval <= '0;
            drum_primed <= 1'h1;
            // edge to edge is the count plus the edge cycle itself; a
            // partial first interval or a stalled drum gives no burst
            if (drum_primed && drum_interval != '1) begin
                drum_period <= drum_interval + 1'h1;
            end else begin
                drum_period <= '0;
            end
        end else if (drum_interval != '1) begin
            drum_interval <= drum_interval + 1'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            drum_phase <= '0;
            drum_left <= 3'h0;
            drum_stb <= 1'h0;
        end else if (drum_edge && drum_quarter != '0) begin
            drum_phase <= '0;
            drum_left <= 3'(csbg_pkg::DRUM_MULTIPLY - 1);
            drum_stb <= 1'h1;
        end else if (drum_left != 3'h0 && drum_phase + 1'h1 >= drum_quarter)
        begin
            drum_phase <= '0;
            drum_left <= drum_left - 3'h1;
            drum_stb <= 1'h1;
        end else begin
            // idle counter stands still between bursts
            if (drum_left != 3'h0) begin
                drum_phase <= drum_phase + 1'h1;
            end
            drum_stb <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // free-running oscillator strobe
    localparam int unsigned OSC_W = $clog2(csbg_pkg::OSC_PERIOD_CYC);
    logic [OSC_W-1:0] osc_count;
    logic osc_stb;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            osc_count <= '0;
            osc_stb <= 1'h0;
        end else if (osc_count == OSC_W'(csbg_pkg::OSC_PERIOD_CYC - 1)) begin
            osc_count <= '0;
            osc_stb <= 1'h1;
        end else begin
            osc_count <= osc_count + 1'h1;
            osc_stb <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source selector
    // oscillator hold only exists under test mode; in normal mode the
    // release sequence always runs, so the drum is selected whatever
    // the oscillator button says
    logic osc_hold;
    logic clk_stb;
    assign osc_hold = pnl.test_mode & pnl.osc_select;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            source_sel_flop_a <= csbg_pkg::SRC_SEL_RESET;
            source_sel_flop_b <= csbg_pkg::SRC_SEL_RESET;
        end else begin
            if (osc_hold) begin
                source_sel_flop_a <= 1'h0;
            end else if (osc_stb && !source_sel_flop_a && !source_sel_flop_b)
            begin
                source_sel_flop_a <= 1'h1;
            end
            if (osc_stb && !source_sel_flop_a && source_sel_flop_b) begin
                source_sel_flop_b <= 1'h0;
            end else if (drum_stb && source_sel_flop_a && !source_sel_flop_b)
            begin
                source_sel_flop_b <= 1'h1;
            end
        end
    end

    // transitional selector states forward nothing, so no runt pulse
    // a switch to the oscillator can drop up to two pulses, back to the drum at most one; never the whole stream
    always_comb begin
        clk_stb = 1'h0;
        if (source_sel_flop_a && source_sel_flop_b) begin
            clk_stb = drum_stb;
        end else if (!source_sel_flop_a && !source_sel_flop_b) begin
            clk_stb = osc_stb;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            osc_source_active <= 1'h0;
        end else begin
            osc_source_active <= ~source_sel_flop_a & ~source_sel_flop_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timed step source: phase accumulator, rate clamped to the knob range
    logic auto_enable;
    logic [5:0] rate_clamped;
    logic [STEP_ACC_W-1:0] step_acc;
    logic slow_stb;

    // knob ends, sized to the rate port once so the compares stay 6 bits
    localparam logic [5:0] RATE_LO = 6'(csbg_pkg::STEP_RATE_MIN_CPS);
    localparam logic [5:0] RATE_HI = 6'(csbg_pkg::STEP_RATE_MAX_CPS);

    always_comb begin
        rate_clamped = step_rate_cps;
        if (step_rate_cps < RATE_LO) begin
            rate_clamped = RATE_LO;
        end else if (step_rate_cps > RATE_HI) begin
            rate_clamped = RATE_HI;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            auto_enable <= 1'h0;
        end else if (run_mode != csbg_pkg::CSBG_RUN_AUTO_STEP || stop_pulse)
        begin
            auto_enable <= 1'h0;
        end else if (start_pulse) begin
            auto_enable <= 1'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            step_acc <= '0;
            slow_stb <= 1'h0;
        end else if (!auto_enable) begin
            step_acc <= '0;
            slow_stb <= 1'h0;
        end else if (step_acc + STEP_ACC_W'(rate_clamped)
                     >= STEP_ACC_W'(CLK_HZ)) begin
            step_acc <= step_acc + STEP_ACC_W'(rate_clamped)
                        - STEP_ACC_W'(CLK_HZ);
            slow_stb <= 1'h1;
        end else begin
            step_acc <= step_acc + STEP_ACC_W'(rate_clamped);
            slow_stb <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rate controller
    logic begin_req;
    logic gap_req;
    logic ctrl_stb;
    logic step_mode;
    assign step_mode = run_mode != csbg_pkg::CSBG_RUN_CONT;
    assign gap_req = seq_req.special_sequence_init
                     | seq_req.operand_to_prog_ctrl_transfer;
    assign ctrl_stb = clk_stb & ~rate_flop_b;

    always_comb begin
        begin_req = 1'h0;
        case (run_mode)
            csbg_pkg::CSBG_RUN_CONT: begin
                begin_req = start_pulse & (pnl.drum_start | pnl.tape_start);
            end
            csbg_pkg::CSBG_RUN_MAN_STEP: begin
                begin_req = step_pulse;
            end
            csbg_pkg::CSBG_RUN_AUTO_STEP: begin
                begin_req = slow_stb;
            end
            default: begin
                begin_req = 1'h0;
            end
        endcase
    end

    // priority: stop, then the emitted step pulse, then begin and gap; a
    // gap that meets a strobe still wins over clearing b
    // resume signals are not inputs at all: the rate flops see only
    // start, stop, step, the slow step strobe, gap requests and the selected clock strobe
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rate_flop_a <= csbg_pkg::RATE_RESET;
            rate_flop_b <= csbg_pkg::RATE_RESET;
        end else if (stop_pulse) begin
            rate_flop_a <= 1'h1;
            rate_flop_b <= 1'h1;
        end else if (step_mode && ctrl_stb) begin
            rate_flop_a <= 1'h1;
            rate_flop_b <= 1'h1;
        end else begin
            if (begin_req) begin
                rate_flop_a <= 1'h0;
            end
            if (gap_req && !rate_flop_a) begin
                rate_flop_b <= 1'h1;
            end else if (clk_stb && !rate_flop_a) begin
                rate_flop_b <= 1'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse shapers: fixed width, strobes never overlap at 20 cycles apart
    localparam int unsigned PW_W = $clog2(csbg_pkg::PULSE_WIDTH_CYC + 1);
    logic [PW_W-1:0] cpu_width;
    logic [PW_W-1:0] ctrl_width;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_width <= '0;
            computer_clock <= 1'h0;
        end else if (clk_stb) begin
            cpu_width <= PW_W'(csbg_pkg::PULSE_WIDTH_CYC - 1);
            computer_clock <= 1'h1;
        end else if (cpu_width != '0) begin
            cpu_width <= cpu_width - 1'h1;
        end else begin
            computer_clock <= 1'h0;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_width <= '0;
            controlled_clock <= 1'h0;
        end else if (ctrl_stb) begin
            ctrl_width <= PW_W'(csbg_pkg::PULSE_WIDTH_CYC - 1);
            controlled_clock <= 1'h1;
        end else if (ctrl_width != '0) begin
            ctrl_width <= ctrl_width - 1'h1;
        end else begin
            controlled_clock <= 1'h0;
        end
    end

endmodule

// File: csbg_top_asserts.sv
// concurrent checks on the clock source and burst gate ports
`timescale 1ns/10ps
module csbg_top_asserts (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire csbg_pkg::csbg_panel_s panel,
    input wire csbg_pkg::csbg_run_e run_mode,
    input wire logic [5:0] step_rate_cps,
    input wire csbg_pkg::csbg_seq_s seq_req,
    input wire logic computer_clock,
    input wire logic controlled_clock,
    input wire logic source_sel_flop_a,
    input wire logic source_sel_flop_b,
    input wire logic rate_flop_a,
    input wire logic rate_flop_b,
    input wire logic osc_source_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    // cycles outside test mode; drum must own the clock well before 100
    logic [7:0] norm_cnt;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            norm_cnt <= 8'h00;
        else if (panel.test_mode)
            norm_cnt <= 8'h00;
        else if (norm_cnt != 8'hFF)
            norm_cnt <= norm_cnt + 8'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    a_clk_width: assert property ($rose(computer_clock) |->
        computer_clock [*3] ##1 !computer_clock)
        else $error("computer clock pulse width wrong");
    a_ctrl_width: assert property ($rose(controlled_clock) |->
        controlled_clock [*3] ##1 !controlled_clock)
        else $error("controlled clock pulse width wrong");
    a_drum_owns: assert property (norm_cnt >= 8'h64 |->
        source_sel_flop_a && source_sel_flop_b && !osc_source_active)
        else $error("drum source not selected outside test mode");
    a_hold_clears_a: assert property (
        (panel.test_mode && panel.osc_select) [*4] |-> !source_sel_flop_a)
        else $error("selector flop a not held low");
    a_stop_sets: assert property ($rose(panel.stop) |->
        ##[1:6] (rate_flop_a && rate_flop_b))
        else $error("stop did not set rate flops");
    a_emit_b_low: assert property ($rose(controlled_clock) |->
        !$past(rate_flop_b))
        else $error("gated pulse while rate flop b set");
    a_gated_subset: assert property ($rose(controlled_clock) |->
        $rose(computer_clock))
        else $error("gated pulse not aligned to clock pulse");
    a_step_ends: assert property ($rose(controlled_clock) &&
        run_mode != csbg_pkg::CSBG_RUN_CONT |->
        ##[0:2] (rate_flop_a && rate_flop_b))
        else $error("step pulse did not end operation");
    a_gap_sets_b: assert property (!rate_flop_a && |seq_req |->
        ##1 rate_flop_b)
        else $error("gap request did not set rate flop b");
    c_gated: cover property ($rose(controlled_clock));
    c_osc: cover property ($rose(osc_source_active));
    c_gap: cover property (!rate_flop_a && |seq_req);
endmodule
bind csbg_top csbg_top_asserts u_chk (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .panel(panel), .run_mode(run_mode),
    .step_rate_cps(step_rate_cps), .seq_req(seq_req),
    .computer_clock(computer_clock), .controlled_clock(controlled_clock),
    .source_sel_flop_a(source_sel_flop_a),
    .source_sel_flop_b(source_sel_flop_b), .rate_flop_a(rate_flop_a),
    .rate_flop_b(rate_flop_b), .osc_source_active(osc_source_active));

// File: csbg_drum_model.sv
// drum timing pulse source standing in for the drum read track
`timescale 1ns/10ps
module csbg_drum_model #(
    parameter int unsigned PERIOD_NS = 8000,
    parameter int unsigned HIGH_NS = 500
) (
    input wire logic spin,
    output logic drum_timing
);
    // odd offset keeps it out of phase with clk_sys; stopped drum is silent
    initial begin
        drum_timing = 1'b0;
        #37;
        forever begin
            if (spin) begin
                drum_timing = 1'b1;
                #(HIGH_NS);
            end
            drum_timing = 1'b0;
            #(PERIOD_NS - HIGH_NS);
        end
    end
endmodule

// File: tb_clock_source_and_burst_gate.sv
// self-checking bench for the clock source and burst gate
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    err_total++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end end
module tb_clock_source_and_burst_gate;
    logic clk_sys, sys_rst, spin, drum_tp;
    logic comp_clk, ctrl_clk, ss_a, ss_b, rf_a, rf_b, osc_act;
    csbg_pkg::csbg_panel_s pan, panel_in;
    csbg_pkg::csbg_run_e run_mode;
    csbg_pkg::csbg_seq_s seq_req;
    logic [5:0] step_rate_cps;
    int err_total = 0;
    int total_checks = 0;
    int nc, nk;
    always_comb begin
        panel_in = pan;
        panel_in.drum_timing = drum_tp;
    end
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    csbg_drum_model drum (.spin(spin), .drum_timing(drum_tp));
    // small modulus: slow step strobes every CLK_HZ / rate cycles
    csbg_top #(.CLK_HZ(1000)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .panel(panel_in), .run_mode(run_mode),
        .step_rate_cps(step_rate_cps), .seq_req(seq_req),
        .computer_clock(comp_clk), .controlled_clock(ctrl_clk),
        .source_sel_flop_a(ss_a), .source_sel_flop_b(ss_b),
        .rate_flop_a(rf_a), .rate_flop_b(rf_b), .osc_source_active(osc_act));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic count(input int n);
        logic pc, pk;
        nc = 0;
        nk = 0;
        pc = comp_clk;
        pk = ctrl_clk;
        repeat (n) begin
            tick(1);
            if (comp_clk === 1'b1 && pc !== 1'b1) nc++;
            if (ctrl_clk === 1'b1 && pk !== 1'b1) nk++;
            pc = comp_clk;
            pk = ctrl_clk;
        end
    endtask
    // held high for 8 cycles: only the edge may act
    task automatic press(input int b);
        @(posedge clk_sys);
        if (b == 0) pan.start <= 1'b1;
        else if (b == 1) pan.stop <= 1'b1;
        else pan.step <= 1'b1;
        repeat (8) @(posedge clk_sys);
        pan.start <= 1'b0;
        pan.stop <= 1'b0;
        pan.step <= 1'b0;
        tick(2);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_run(input logic tape);
        @(posedge clk_sys);
        pan.drum_start <= !tape;
        pan.tape_start <= tape;
        press(0);
        count(100);
        count(400);
        `CHK("pulses", 20, nc)
        `CHK("gated", nc, nk)
        `CHK("osc_act", 1'b0, osc_act)
        for (int g = 0; g < 2; g++) begin
            @(posedge clk_sys) seq_req <= (g == 0) ? 2'h2 : 2'h1;
            @(posedge clk_sys) seq_req <= 2'h0;
            tick(0);
            count(200);
            `CHK("gap", 1, nc - nk)
        end
        press(1);
        count(200);
        `CHK("after_stop", 0, nk)
        `CHK("rate_ab", 2'h3, {rf_a, rf_b})
    endtask
    task automatic t_noqual();
        @(posedge clk_sys);
        pan.drum_start <= 1'b0;
        pan.tape_start <= 1'b0;
        press(0);
        count(200);
        `CHK("unqualified", 0, nk)
        press(1);
    endtask
    task automatic t_manual();
        @(posedge clk_sys) run_mode <= csbg_pkg::CSBG_RUN_MAN_STEP;
        press(0);
        count(100);
        `CHK("start_man", 0, nk)
        repeat (2) begin
            press(2);
            count(150);
            `CHK("one_step", 1, nk)
            `CHK("step_ab", 2'h3, {rf_a, rf_b})
        end
    endtask
    task automatic t_timed();
        @(posedge clk_sys) run_mode <= csbg_pkg::CSBG_RUN_AUTO_STEP;
        step_rate_cps <= 6'h05;
        press(2);
        count(300);
        `CHK("idle_timed", 0, nk)
        press(0);
        count(1100);
        `CHK("slow_steps", 5, nk)
        press(1);
        @(posedge clk_sys) run_mode <= csbg_pkg::CSBG_RUN_CONT;
    endtask
    task automatic t_osc();
        @(posedge clk_sys) pan.test_mode <= 1'b1;
        tick(50);
        `CHK("drum_choice", 1'b0, osc_act)
        @(posedge clk_sys) pan.osc_select <= 1'b1;
        tick(60);
        `CHK("osc_hold", 2'h1, {ss_a, osc_act})
        @(posedge clk_sys) spin <= 1'b0;
        tick(200);
        count(400);
        `CHK("osc_pulses", 20, nc)
        @(posedge clk_sys) spin <= 1'b1;
        tick(200);
        @(posedge clk_sys) pan.osc_select <= 1'b0;
        count(300);
        `CHK("back_drum", 2'h3, {ss_a, ss_b})
        `CHK("no_block", 1'b1, nc >= 13)
        @(posedge clk_sys) pan.test_mode <= 1'b0;
        pan.osc_select <= 1'b1;
        tick(100);
        `CHK("osc_normal", 1'b0, osc_act)
        @(posedge clk_sys) pan.osc_select <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        spin = 1'b1;
        pan = '0;
        run_mode = csbg_pkg::CSBG_RUN_CONT;
        step_rate_cps = 6'h23;
        seq_req = '0;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        tick(200);
        `CHK("reset_ab", 2'h3, {rf_a, rf_b})
        `CHK("reset_sel", 2'h3, {ss_a, ss_b})
        for (int q = 0; q < 2; q++)
            t_run(q[0]);
        t_noqual();
        t_manual();
        t_timed();
        t_osc();
        close_out();
    end
    // whole run is near 5900 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        close_out();
    end
endmodule
